// ===== hdl/rct_params.svh
// Register offsets, field positions and reset values of the reload capture timer
`ifndef RCT_PARAMS_SVH
`define RCT_PARAMS_SVH
`define RCT_ADDR_W        8
`define RCT_OFF_CONTROL   8'hC8
`define RCT_OFF_RCAP_LO   8'hCA
`define RCT_OFF_RCAP_HI   8'hCB
`define RCT_OFF_CNT_LO    8'hCC
`define RCT_OFF_CNT_HI    8'hCD
`define RCT_OFF_IRQ_STAT  8'hD0
`define RCT_OFF_IRQ_EN    8'hD4
`define RCT_OFF_IRQ_CLR   8'hD8
`define RCT_BIT_OVF       7
`define RCT_BIT_EXT       6
`define RCT_BIT_RXBAUD    5
`define RCT_BIT_TXBAUD    4
`define RCT_BIT_TRIG_EN   3
`define RCT_BIT_RUN       2
`define RCT_BIT_SRC       1
`define RCT_BIT_CAPRL     0
`define RCT_CTRL_RESET    8'h00
`define RCT_BYTE_RESET    8'h00
`define RCT_TIMER_DIV     2
`define RCT_IRQ_OVF       0
`define RCT_IRQ_EXT       1
`define RCT_IRQ_CAPT      2
`define RCT_IRQ_W         3
`endif

// ===== hdl/rct_pkg.sv
// Types of the reload capture timer
package rct_pkg;
  typedef logic [7:0]  rct_byte_t;
  typedef logic [15:0] rct_count_t;
  typedef enum logic [1:0] {
    RCT_BUS_IDLE = 2'b00,
    RCT_BUS_ACK  = 2'b01
  } rct_bus_state_t;
endpackage

// ===== hdl/rct_sync_edge.sv
// Two-stage synchroniser with falling edge detector
`timescale 1ns/10ps
`default_nettype none
module rct_sync_edge (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic pin,
  output var  logic fall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic fall;
  } rct_sync_state_t;

  rct_sync_state_t st_q;
  rct_sync_state_t st_d;

  always_comb begin
    st_d      = st_q;
    st_d.s1   = pin;
    st_d.s2   = st_q.s1;
    st_d.s3   = st_q.s2;
    st_d.fall = st_q.s3 & ~st_q.s2;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, fall: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign fall = st_q.fall;

  property p_one_pulse;
    @(posedge clk) disable iff (!reset_n) fall |=> !fall;
  endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("edge pulse longer than one cycle");

  property p_fall_cause;
    @(posedge clk) disable iff (!reset_n) fall |-> $past(st_q.s3) && !$past(st_q.s2);
  endproperty
  a_fall_cause: assert property (p_fall_cause) else $error("edge pulse without falling edge");
endmodule // rct_sync_edge
`default_nettype wire

// ===== hdl/rct_timer.sv
// Reload capture timer: 16-bit counter with reload, capture, baud output and Wishbone registers
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
`include "rct_params.svh"
// How it works
// - An overflow sets the overflow flag unless a baud select is 1; software clears it.
// - With the trigger enable set, a trigger-pin capture or reload sets the edge flag.
// - Receive baud select 1 sends this overflow to the UART receive clock, else Timer1 overflow.
// - Transmit baud select 1 sends this overflow to the UART transmit clock, else Timer1 overflow.
// - Trigger enable with both baud selects 0 lets a trigger falling edge capture or reload.
// - Timer source with run set counts once per two clocks; run clear stops counting.
// - Count source select 1 counts falling edges of the count pin instead.
// - Reload mode reloads on overflow and on enabled trigger edges.
// - Capture mode captures on enabled trigger edges and, with both baud selects 0, does not reload on overflow.
// - Any baud select forces auto-reload on overflow regardless of capture mode.
// - Reload/capture value sits in byte registers at CAh and CBh, reset to zero.
// - Count sits in byte registers at CCh and CDh, reset to zero, read and preset by software.
module rct_timer (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_we_i,
  input  wire logic [7:0] wb_adr_i,
  input  wire logic [3:0] wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic       wb_ack_o,
  input  wire logic       count_pin,
  input  wire logic       trigger_pin,
  input  wire logic       timer1_ovf,
  output var  logic       rx_baud_tick,
  output var  logic       tx_baud_tick,
  output var  logic       irq
);
  typedef struct packed {
    rct_pkg::rct_bus_state_t bus;
    logic [31:0]             rdata;
    rct_pkg::rct_byte_t      ctrl;
    rct_pkg::rct_count_t     rcap;
    rct_pkg::rct_count_t     cnt;
    logic                    div;
    logic [`RCT_IRQ_W-1:0]   stat;
    logic [`RCT_IRQ_W-1:0]   en;
    logic                    irq;
    logic                    rx_tick;
    logic                    tx_tick;
  } rct_state_t;

  rct_state_t st_q;
  rct_state_t st_d;
  logic       cnt_fall;
  logic       trg_fall;

  rct_sync_edge u_count_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .pin     (count_pin),
    .fall    (cnt_fall)
  );

  rct_sync_edge u_trig_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .pin     (trigger_pin),
    .fall    (trg_fall)
  );

  logic       baud_mode;
  logic       step;
  logic       ovf;
  logic       trig_ok;
  logic       do_reload;
  logic       do_capture;
  logic       wr_stb;
  logic       rd_stb;
  logic [7:0] wbyte;
  logic [`RCT_IRQ_W-1:0] ev;
  logic [`RCT_IRQ_W-1:0] clr;

  always_comb begin
    baud_mode = st_q.ctrl[`RCT_BIT_RXBAUD] | st_q.ctrl[`RCT_BIT_TXBAUD];
    // Count pulse from the selected source
    if (st_q.ctrl[`RCT_BIT_SRC]) begin
      step = st_q.ctrl[`RCT_BIT_RUN] & cnt_fall;
    end else begin
      step = st_q.ctrl[`RCT_BIT_RUN] & st_q.div;
    end
    ovf        = step & (st_q.cnt == 16'hFFFF);
    trig_ok    = trg_fall & st_q.ctrl[`RCT_BIT_TRIG_EN] & ~baud_mode;
    do_capture = trig_ok & st_q.ctrl[`RCT_BIT_CAPRL] & ~baud_mode;
    do_reload  = (ovf & (baud_mode | ~st_q.ctrl[`RCT_BIT_CAPRL]))
               | (trig_ok & ~st_q.ctrl[`RCT_BIT_CAPRL]);
    // Write lands on the edge at which the master samples ack high
    wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & (st_q.bus == rct_pkg::RCT_BUS_ACK) & wb_sel_i[0];
    rd_stb = wb_cyc_i & wb_stb_i & ~wb_we_i & (st_q.bus == rct_pkg::RCT_BUS_IDLE);
    wbyte  = wb_dat_i[7:0];
    ev  = '0;
    ev[`RCT_IRQ_OVF]  = ovf & ~baud_mode;
    ev[`RCT_IRQ_EXT]  = trig_ok;
    ev[`RCT_IRQ_CAPT] = do_capture;
    clr = '0;
    if (wr_stb && wb_adr_i == `RCT_OFF_IRQ_CLR) begin
      clr = wbyte[`RCT_IRQ_W-1:0];
    end

    st_d         = st_q;
    st_d.div     = st_q.ctrl[`RCT_BIT_RUN] ? ~st_q.div : 1'b0;
    st_d.rx_tick = st_q.ctrl[`RCT_BIT_RXBAUD] ? ovf : timer1_ovf;
    st_d.tx_tick = st_q.ctrl[`RCT_BIT_TXBAUD] ? ovf : timer1_ovf;

    // Software access; reload, capture and flag sets below take priority, a count step yields to a count write
    if (wr_stb) begin
      case (wb_adr_i)
        `RCT_OFF_CONTROL: st_d.ctrl      = wbyte;
        `RCT_OFF_RCAP_LO: st_d.rcap[7:0]  = wbyte;
        `RCT_OFF_RCAP_HI: st_d.rcap[15:8] = wbyte;
        `RCT_OFF_CNT_LO:  st_d.cnt[7:0]   = wbyte;
        `RCT_OFF_CNT_HI:  st_d.cnt[15:8]  = wbyte;
        `RCT_OFF_IRQ_EN:  st_d.en         = wbyte[`RCT_IRQ_W-1:0];
        default:          st_d.ctrl       = st_q.ctrl;
      endcase
    end

    if (do_reload) begin
      st_d.cnt = st_q.rcap;
    end else if (step && !(wr_stb && (wb_adr_i == `RCT_OFF_CNT_LO || wb_adr_i == `RCT_OFF_CNT_HI))) begin
      st_d.cnt = st_q.cnt + 16'h0001;
    end
    if (do_capture) begin
      st_d.rcap = st_q.cnt;
    end

    // Flags: set wins over software clear
    if (ovf && !baud_mode) begin
      st_d.ctrl[`RCT_BIT_OVF] = 1'b1;
    end
    if (trig_ok) begin
      st_d.ctrl[`RCT_BIT_EXT] = 1'b1;
    end
    st_d.stat = (st_q.stat & ~clr) | ev;
    st_d.irq  = |(st_d.stat & st_d.en);

    st_d.bus = rct_pkg::RCT_BUS_IDLE;
    if (wb_cyc_i && wb_stb_i && st_q.bus == rct_pkg::RCT_BUS_IDLE) begin
      st_d.bus = rct_pkg::RCT_BUS_ACK;
    end
    if (rd_stb) begin
      st_d.rdata = 32'h0000_0000;
      case (wb_adr_i)
        `RCT_OFF_CONTROL:  st_d.rdata[7:0] = st_q.ctrl;
        `RCT_OFF_RCAP_LO:  st_d.rdata[7:0] = st_q.rcap[7:0];
        `RCT_OFF_RCAP_HI:  st_d.rdata[7:0] = st_q.rcap[15:8];
        `RCT_OFF_CNT_LO:   st_d.rdata[7:0] = st_q.cnt[7:0];
        `RCT_OFF_CNT_HI:   st_d.rdata[7:0] = st_q.cnt[15:8];
        `RCT_OFF_IRQ_STAT: st_d.rdata[`RCT_IRQ_W-1:0] = st_q.stat;
        `RCT_OFF_IRQ_EN:   st_d.rdata[`RCT_IRQ_W-1:0] = st_q.en;
        default:           st_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign wb_dat_o     = st_q.rdata;
  assign wb_ack_o     = st_q.bus[0];
  assign rx_baud_tick = st_q.rx_tick;
  assign tx_baud_tick = st_q.tx_tick;
  assign irq          = st_q.irq;

  sequence s_ovf_timer;
    !st_q.ctrl[`RCT_BIT_SRC] && step && st_q.cnt == 16'hFFFF;
  endsequence

  property p_ovf_flag;
    @(posedge clk) disable iff (!reset_n) ovf && !baud_mode |=> st_q.ctrl[`RCT_BIT_OVF];
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");

  property p_no_ovf_flag_baud;
    @(posedge clk) disable iff (!reset_n)
      baud_mode && !st_q.ctrl[`RCT_BIT_OVF] && !wr_stb |=> !st_q.ctrl[`RCT_BIT_OVF];
  endproperty
  a_no_ovf_flag_baud: assert property (p_no_ovf_flag_baud) else $error("overflow flag in baud mode");

  property p_ext_flag;
    @(posedge clk) disable iff (!reset_n) trig_ok |=> st_q.ctrl[`RCT_BIT_EXT];
  endproperty
  a_ext_flag: assert property (p_ext_flag) else $error("edge flag not set");

  property p_rx_baud;
    @(posedge clk) disable iff (!reset_n)
      st_q.ctrl[`RCT_BIT_RXBAUD] |=> rx_baud_tick == $past(ovf);
  endproperty
  a_rx_baud: assert property (p_rx_baud) else $error("receive tick not from overflow");

  property p_tx_baud;
    @(posedge clk) disable iff (!reset_n)
      !st_q.ctrl[`RCT_BIT_TXBAUD] |=> tx_baud_tick == $past(timer1_ovf);
  endproperty
  a_tx_baud: assert property (p_tx_baud) else $error("transmit tick not from timer1");

  property p_trig_ignored;
    @(posedge clk) disable iff (!reset_n)
      trg_fall && !st_q.ctrl[`RCT_BIT_TRIG_EN] |-> !trig_ok;
  endproperty
  a_trig_ignored: assert property (p_trig_ignored) else $error("disabled trigger acted");

  property p_timer_rate;
    @(posedge clk) disable iff (!reset_n)
      step && !st_q.ctrl[`RCT_BIT_SRC] |=> !step;
  endproperty
  a_timer_rate: assert property (p_timer_rate) else $error("timer counts faster than half clock");

  property p_stopped;
    @(posedge clk) disable iff (!reset_n) !st_q.ctrl[`RCT_BIT_RUN] |-> !step;
  endproperty
  a_stopped: assert property (p_stopped) else $error("count while stopped");

  property p_reload;
    @(posedge clk) disable iff (!reset_n) s_ovf_timer and !st_q.ctrl[`RCT_BIT_CAPRL] |=>
      st_q.cnt == $past(st_q.rcap);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload on overflow");

  property p_capture;
    @(posedge clk) disable iff (!reset_n) do_capture |=> st_q.rcap == $past(st_q.cnt);
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_force_reload;
    @(posedge clk) disable iff (!reset_n) ovf && baud_mode |-> do_reload && !do_capture;
  endproperty
  a_force_reload: assert property (p_force_reload) else $error("baud mode did not reload");
endmodule // rct_timer
`default_nettype wire

// ===== test/rct_pin_model.sv
// Count pin, trigger pin and Timer1 overflow source
`timescale 1ns/10ps
`default_nettype none
module rct_pin_model (
  input  wire logic clk,
  output var  logic count_pin,
  output var  logic trigger_pin,
  output var  logic timer1_ovf
);
  initial begin
    count_pin = 1'b1;
    trigger_pin = 1'b1;
    timer1_ovf = 1'b0;
  end
  // Pins idle high; each pulse gives one falling edge
  task automatic fall(input int which, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (which == 0) count_pin <= 1'b0;
      else trigger_pin <= 1'b0;
      repeat (gap) @(posedge clk);
      count_pin <= 1'b1;
      trigger_pin <= 1'b1;
      repeat (gap) @(posedge clk);
    end
  endtask
  task automatic t1_tick();
    @(posedge clk);
    timer1_ovf <= 1'b1;
    @(posedge clk);
    timer1_ovf <= 1'b0;
  endtask
endmodule // rct_pin_model
`default_nettype wire

// ===== test/tb_reload_capture_timer.sv
// Self-checking bench for the reload capture timer
`timescale 1ns/10ps
`default_nettype none
`include "rct_params.svh"
module tb_reload_capture_timer;
  logic        clk, reset_n, cyc, stb, we;
  logic [7:0]  adr, q;
  logic [3:0]  sel;
  logic [31:0] dat;
  wire logic [31:0] dat_o;
  wire logic   ack, cpin, tpin, t1, rxt, txt, irq;
  int          mismatches, total_checks, cycles, rx_n, tx_n;
  logic [7:0]  offs[6] = '{8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hC9};
  rct_timer u_dut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .count_pin(cpin), .trigger_pin(tpin), .timer1_ovf(t1),
    .rx_baud_tick(rxt), .tx_baud_tick(txt), .irq(irq));
  rct_pin_model u_pins (.clk(clk), .count_pin(cpin), .trigger_pin(tpin), .timer1_ovf(t1));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rxt === 1'b1) rx_n <= rx_n + 1;
    if (txt === 1'b1) tx_n <= tx_n + 1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n == 50) mismatches++;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input string s);
    bus(1'b0, a, 8'h00);
    chk(s, e, {8'h00, q});
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    bus(1'b1, a, v[7:0]);
    bus(1'b1, a + 8'h01, v[15:8]);
  endtask
  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    bus(1'b0, a, 8'h00);
    v[7:0] = q;
    bus(1'b0, a + 8'h01, 8'h00);
    v[15:8] = q;
  endtask
  initial begin
    logic [15:0] v, m_cnt, m_rc;
    int x, y, n;
    {cyc, stb, we, adr, dat, sel} = '0;
    sel = 4'hF;
    reset_n = 1'b0;
    {mismatches, total_checks, cycles, rx_n, tx_n} = '0;
    void'($urandom(92));
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    bus(1'b1, 8'hC9, 8'hFF);
    foreach (offs[i]) rd(offs[i], 16'h0000, "reset_or_unmapped");
    m_rc = 16'($urandom);
    m_cnt = 16'($urandom);
    wr16(`RCT_OFF_RCAP_LO, m_rc);
    wr16(`RCT_OFF_CNT_LO, m_cnt);
    rd16(`RCT_OFF_RCAP_LO, v);
    chk("reload_reg", m_rc, v);
    rd16(`RCT_OFF_CNT_LO, v);
    chk("count_reg", m_cnt, v);
    $display("test registers done");
    m_rc = 16'h1000 + 16'($urandom % 256);
    wr16(`RCT_OFF_RCAP_LO, m_rc);
    wr16(`RCT_OFF_CNT_LO, 16'hFFF8);
    bus(1'b1, `RCT_OFF_CONTROL, 8'h04);
    repeat (40) @(posedge clk);
    rd(`RCT_OFF_CONTROL, 16'h0084, "ovf_flag");
    bus(1'b1, `RCT_OFF_CONTROL, 8'h00);
    rd16(`RCT_OFF_CNT_LO, v);
    chk("reload_span", 16'h0001, 16'((v - m_rc) inside {[10:16]}));
    repeat (10) @(posedge clk);
    rd16(`RCT_OFF_CNT_LO, m_cnt);
    chk("stopped", v, m_cnt);
    $display("test timer done");
    wr16(`RCT_OFF_RCAP_LO, 16'hFFF0);
    for (int k = 0; k < 2; k++) begin
      wr16(`RCT_OFF_CNT_LO, 16'hFFF0);
      x = rx_n;
      y = tx_n;
      bus(1'b1, `RCT_OFF_CONTROL, k ? 8'h15 : 8'h25);
      repeat (3) u_pins.t1_tick();
      repeat (200) @(posedge clk);
      rd(`RCT_OFF_CONTROL, k ? 16'h0015 : 16'h0025, "baud_no_flag");
      bus(1'b1, `RCT_OFF_CONTROL, 8'h00);
      chk("t1_ticks", 16'h0003, 16'(k ? rx_n - x : tx_n - y));
      chk("own_ticks", 16'h0001, 16'((k ? tx_n - y : rx_n - x) inside {[5:8]}));
    end
    $display("test baud done");
    n = 1 + $urandom % 6;
    wr16(`RCT_OFF_CNT_LO, 16'h0010);
    bus(1'b1, `RCT_OFF_CONTROL, 8'h06);
    u_pins.fall(0, n, 1 + $urandom % 4);
    repeat (8) @(posedge clk);
    bus(1'b1, `RCT_OFF_CONTROL, 8'h00);
    rd16(`RCT_OFF_CNT_LO, v);
    chk("pin_count", 16'h0010 + 16'(n), v);
    $display("test counter done");
    bus(1'b1, `RCT_OFF_IRQ_EN, 8'h02);
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, `RCT_OFF_IRQ_CLR, 8'h07);
      m_cnt = 16'($urandom);
      wr16(`RCT_OFF_RCAP_LO, 16'h4321);
      wr16(`RCT_OFF_CNT_LO, m_cnt);
      bus(1'b1, `RCT_OFF_CONTROL, 8'h06 | (k ? 8'h08 : 8'h00) | 8'(k == 2));
      u_pins.fall(1, 1, 3);
      repeat (6) @(posedge clk);
      rd(`RCT_OFF_CONTROL, {8'h00, 8'h06 | (k ? 8'h48 : 8'h00) | 8'(k == 2)}, "edge_flag");
      chk("irq", 16'(k != 0), {15'h0000, irq});
      bus(1'b1, `RCT_OFF_CONTROL, 8'h00);
      rd16(`RCT_OFF_CNT_LO, v);
      chk("trig_count", k == 1 ? 16'h4321 : m_cnt, v);
      rd16(`RCT_OFF_RCAP_LO, v);
      chk("trig_rcap", k == 2 ? m_cnt : 16'h4321, v);
    end
    rd(`RCT_OFF_IRQ_STAT, 16'h0006, "irq_status");
    bus(1'b1, `RCT_OFF_IRQ_EN, 8'h00);
    repeat (2) @(posedge clk);
    chk("irq_masked", 16'h0000, {15'h0000, irq});
    bus(1'b1, `RCT_OFF_IRQ_EN, 8'h02);
    bus(1'b1, `RCT_OFF_IRQ_CLR, 8'h02);
    repeat (2) @(posedge clk);
    chk("irq_cleared", 16'h0000, {15'h0000, irq});
    $display("test trigger and irq done");
    final_report();
  end
endmodule // tb_reload_capture_timer
`default_nettype wire
